// >>> torque_cmd_pkg.sv
`default_nettype none
package torque_cmd_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h0000;
    localparam logic [11:0] OFS_ANA_SCALE = 12'h0004;
    localparam logic [11:0] OFS_PRESET_1 = 12'h0008;
    localparam logic [11:0] OFS_PRESET_2 = 12'h000C;
    localparam logic [11:0] OFS_PRESET_3 = 12'h0010;
    localparam logic [11:0] OFS_IO_TORQUE = 12'h0014;
    localparam logic [11:0] OFS_TRQ_LPF = 12'h0018;
    localparam logic [11:0] OFS_POS_LPF = 12'h001C;
    localparam logic [11:0] OFS_VEL_LPF = 12'h0020;
    localparam logic [11:0] OFS_VEL_MOV = 12'h0024;
    localparam logic [11:0] OFS_SC_ACC = 12'h0028;
    localparam logic [11:0] OFS_SC_DEC = 12'h002C;
    localparam logic [11:0] OFS_SC_SMOOTH = 12'h0030;
    localparam logic [11:0] OFS_POS_SMOOTH = 12'h0034;
    localparam logic [11:0] OFS_ANA_TLIMIT = 12'h0038;
    localparam logic [11:0] OFS_STATUS = 12'h0040;
    localparam logic [11:0] OFS_SPEED_OUT = 12'h0044;
    localparam logic [11:0] OFS_EXEC_TIME = 12'h0048;
    localparam logic [11:0] OFS_POS_TIMES = 12'h0080;
    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_COMP_EN_BIT = 3;
    localparam int CTRL_PIDX_LSB = 4;
    // Reset values
    localparam logic [15:0] ANA_SCALE_RST = 16'h0064;
    localparam logic [15:0] ANA_TLIMIT_RST = 16'h0064;
    // Analog input: signed counts of 10 mV, so 1000 counts are 10 V
    localparam logic signed [29:0] ANA_DIV = 30'sd1000;
    localparam logic signed [15:0] TRQ_MAX = 16'sh7FFF;
    localparam logic signed [15:0] TRQ_MIN = -16'sh7FFF;
    localparam logic [3:0] FILT_SHIFT_MAX = 4'hA;
    // Sample period
    localparam int CLK_PERIOD_NS = 50;
    localparam int SAMPLE_PERIOD_NS = 100000;
    localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
    typedef enum logic [2:0] {
        PULSE_POSITION_MODE, PROGRAM_POSITION_MODE, SPEED_MODE,
        ZERO_SPEED_REGISTER_MODE, TORQUE_MODE, ZERO_TORQUE_REGISTER_MODE, IO_MODE
    } mode_e;
endpackage
`default_nettype wire

// >>> cmd_filter_if.sv
`default_nettype none
interface cmd_filter_if;
    logic tick;
    logic signed [15:0] x;
    logic [15:0] time_set;
    logic signed [15:0] y;
    modport src (output tick, output x, output time_set, input y);
    modport flt (input tick, input x, input time_set, output y);
endinterface
`default_nettype wire

// >>> cmd_filter.sv
`default_nettype none
module cmd_filter (
    input wire logic i_clock,
    input wire logic i_resetn,
    cmd_filter_if.flt f
);
    logic signed [23:0] acc_q, acc_d, xs;
    logic [3:0] sh;

    always_comb begin
        xs = {f.x, 8'h00};
        sh = (f.time_set > 16'(torque_cmd_pkg::FILT_SHIFT_MAX)) ?
            torque_cmd_pkg::FILT_SHIFT_MAX : f.time_set[3:0];
        acc_d = acc_q;
        if (f.tick) begin
            if (f.time_set == 16'h0000) begin
                acc_d = xs; // [R11]
            end else begin
                acc_d = acc_q + ((xs - acc_q) >>> sh);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            acc_q <= 24'sh00_0000;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign f.y = acc_q[23:8];

    property p_pass_through;
        @(posedge i_clock) disable iff (!i_resetn)
        (f.tick && f.time_set == 16'h0000) |=> (f.y == $past(f.x));
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("filter not bypassed"); // [R11]
endmodule
`default_nettype wire

// >>> torque_command_select.sv
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
// How it works
// [R1] Torque mode, select zero: scaled analog
// [R2] Zero-torque mode ignores analog input
// [R3] Select bits pick preset one to three
// [R4] Zero-torque mode, select zero: command zero
// [R5] Select bits sampled only while servo on
// [R6] IO mode uses host torque register
// [R7] Torque percent is volts times scale over ten
// [R8] Analog scale resets to one hundred
// [R9] Ten volts maps to analog torque limit
// [R10] Sixteen position ramp times plus smoothing
// [R11] Filter time zero means pass-through
// [R12] Separate speed accel, decel, smoothing times
// [R13] Smoothing zero still gives trapezoid ramps
// [R14] Smoothing only when time above one
// [R15] Following compensation from smoothing time, bit
// [R16] Ramp from speed difference; execution time computed
// [R17] Moving average both ends, lowpass end only
// [R18] Configurer picks lowpass or moving filter
// [R19] Clamp torque, update once per sample
// [R20] Presets writable, used from next sample
module torque_command_select (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_torque_select_bit_a,
    input wire logic i_torque_select_bit_b,
    input wire logic i_servo_on_input,
    input wire logic signed [11:0] i_analog_torque,
    input wire logic signed [15:0] i_speed_target,
    output logic signed [15:0] o_torque_cmd,
    output logic [15:0] o_torque_limit,
    output logic signed [15:0] o_speed_cmd,
    output logic o_follow_comp_on,
    output logic o_sample_tick
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] cfg_q [16];
    logic [15:0] cfg_d [16];
    logic [15:0] ptime_q [16];
    logic [15:0] ptime_d [16];
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, acc_phase, in_cfg, in_ptime, in_stat, mapped;
    logic [31:0] status_w;
    logic [31:0] exec_q, exec_d;
    logic [2:0] sync1_q, sync2_q;
    logic [1:0] sel_q, sel_d;
    logic [11:0] tcnt_q, tcnt_d;
    logic tick_q, tick_d;
    logic signed [15:0] trq_raw_q, trq_raw_d, scaled, tlim_d;
    logic signed [29:0] a30, s30, prod, quot;
    torque_cmd_pkg::mode_e mode;
    logic legal, pos_mode, spd_mode, smooth_on, comp_d, ma_on;
    logic signed [15:0] cur_q, cur_d, tgt, tgt_last_q, tgt_last_d;
    logic [15:0] pcnt_q, pcnt_d, acc_t, dec_t, ramp_t, sm_t;
    logic signed [16:0] diff;
    logic [15:0] mag;
    logic signed [15:0] hist_q [8];
    logic signed [15:0] hist_d [8];
    logic signed [18:0] msum;
    logic [1:0] mk;
    logic signed [15:0] mavg;
    logic signed [15:0] trq_out_d, spd_out_d;
    cmd_filter_if f_trq ();
    cmd_filter_if f_smooth ();
    cmd_filter_if f_cmd ();

    localparam logic [3:0] I_CTRL = torque_cmd_pkg::OFS_CTRL[5:2];
    localparam logic [3:0] I_SCALE = torque_cmd_pkg::OFS_ANA_SCALE[5:2];
    localparam logic [3:0] I_P1 = torque_cmd_pkg::OFS_PRESET_1[5:2];
    localparam logic [3:0] I_IO = torque_cmd_pkg::OFS_IO_TORQUE[5:2];
    localparam logic [3:0] I_TLPF = torque_cmd_pkg::OFS_TRQ_LPF[5:2];
    localparam logic [3:0] I_PLPF = torque_cmd_pkg::OFS_POS_LPF[5:2];
    localparam logic [3:0] I_VLPF = torque_cmd_pkg::OFS_VEL_LPF[5:2];
    localparam logic [3:0] I_VMOV = torque_cmd_pkg::OFS_VEL_MOV[5:2];
    localparam logic [3:0] I_SACC = torque_cmd_pkg::OFS_SC_ACC[5:2];
    localparam logic [3:0] I_SDEC = torque_cmd_pkg::OFS_SC_DEC[5:2];
    localparam logic [3:0] I_SSM = torque_cmd_pkg::OFS_SC_SMOOTH[5:2];
    localparam logic [3:0] I_PSM = torque_cmd_pkg::OFS_POS_SMOOTH[5:2];
    localparam logic [3:0] I_TLIM = torque_cmd_pkg::OFS_ANA_TLIMIT[5:2];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: data registered, so each access phase takes two cycles
    always_comb begin
        acc_phase = i_psel && i_penable;
        in_cfg = (i_paddr[11:6] == 6'h00) && (i_paddr[5:2] <= I_TLIM);
        in_ptime = (i_paddr[11:6] == torque_cmd_pkg::OFS_POS_TIMES[11:6]);
        in_stat = (i_paddr == torque_cmd_pkg::OFS_STATUS) ||
            (i_paddr == torque_cmd_pkg::OFS_SPEED_OUT) ||
            (i_paddr == torque_cmd_pkg::OFS_EXEC_TIME);
        mapped = (in_cfg || in_ptime || in_stat) && (i_paddr[1:0] == 2'b00);
        status_w = {12'h000, o_follow_comp_on, smooth_on, sel_q, o_torque_cmd};
        pready_d = acc_phase && !o_pready;
        pslverr_d = pready_d && (!mapped || (i_pwrite && in_stat));
        prdata_d = 32'h0000_0000;
        if (pready_d && !i_pwrite && mapped) begin
            if (in_cfg) begin
                prdata_d = {16'h0000, cfg_q[i_paddr[5:2]]};
            end else if (in_ptime) begin
                prdata_d = {16'h0000, ptime_q[i_paddr[5:2]]};
            end else if (i_paddr == torque_cmd_pkg::OFS_STATUS) begin
                prdata_d = status_w;
            end else if (i_paddr == torque_cmd_pkg::OFS_SPEED_OUT) begin
                prdata_d = {{16{o_speed_cmd[15]}}, o_speed_cmd};
            end else begin
                prdata_d = exec_q;
            end
        end
        cfg_d = cfg_q;
        ptime_d = ptime_q;
        // Write lands at the completing edge
        if (acc_phase && o_pready && i_pwrite && !o_pslverr) begin
            if (in_cfg) begin
                cfg_d[i_paddr[5:2]] = i_pwdata[15:0]; // [R20]
            end else if (in_ptime) begin
                ptime_d[i_paddr[5:2]] = i_pwdata[15:0]; // [R10]
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            for (int i = 0; i < 16; i++) begin
                cfg_q[i] <= 16'h0000;
                ptime_q[i] <= 16'h0000;
            end
            cfg_q[I_SCALE] <= torque_cmd_pkg::ANA_SCALE_RST; // [R8]
            cfg_q[I_TLIM] <= torque_cmd_pkg::ANA_TLIMIT_RST;
        end else begin
            o_pready <= pready_d;
            o_pslverr <= pslverr_d;
            o_prdata <= prdata_d;
            cfg_q <= cfg_d;
            ptime_q <= ptime_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, sample tick, torque source
    always_comb begin
        tcnt_d = (tcnt_q == torque_cmd_pkg::SAMPLE_LAST) ? 12'h000 : tcnt_q + 12'h001;
        tick_d = (tcnt_q == torque_cmd_pkg::SAMPLE_LAST); // [R19]
        sel_d = sync2_q[2] ? sync2_q[1:0] : sel_q; // [R5]
        legal = (cfg_q[I_CTRL][2:0] != 3'b111);
        mode = torque_cmd_pkg::mode_e'(cfg_q[I_CTRL][2:0]);
        a30 = 30'(i_analog_torque);
        s30 = $signed({14'h0000, cfg_q[I_SCALE]});
        prod = a30 * s30;
        quot = prod / torque_cmd_pkg::ANA_DIV; // [R7]
        if (quot > 30'(torque_cmd_pkg::TRQ_MAX)) begin
            scaled = torque_cmd_pkg::TRQ_MAX; // [R19]
        end else if (quot < 30'(torque_cmd_pkg::TRQ_MIN)) begin
            scaled = torque_cmd_pkg::TRQ_MIN;
        end else begin
            scaled = quot[15:0];
        end
        // Limit is magnitude only, so a negative input cannot flip it
        tlim_d = 16'((30'(i_analog_torque[11] ? -i_analog_torque : i_analog_torque)
            * $signed({14'h0000, cfg_q[I_TLIM]})) / torque_cmd_pkg::ANA_DIV); // [R9]
        trq_raw_d = trq_raw_q;
        if (tick_q) begin
            trq_raw_d = 16'sh0000;
            if (sync2_q[2] && legal) begin
                unique case (mode)
                    torque_cmd_pkg::TORQUE_MODE: begin
                        trq_raw_d = (sel_q == 2'b00) ? scaled : // [R1]
                            $signed(cfg_q[I_P1 + 4'(sel_q) - 4'h1]); // [R3]
                    end
                    torque_cmd_pkg::ZERO_TORQUE_REGISTER_MODE: begin
                        trq_raw_d = (sel_q == 2'b00) ? 16'sh0000 : // [R2] [R4]
                            $signed(cfg_q[I_P1 + 4'(sel_q) - 4'h1]); // [R3]
                    end
                    torque_cmd_pkg::IO_MODE: begin
                        trq_raw_d = $signed(cfg_q[I_IO]); // [R6]
                    end
                    default: begin
                        trq_raw_d = 16'sh0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sync1_q <= 3'b000;
            sync2_q <= 3'b000;
            sel_q <= 2'b00;
            tcnt_q <= 12'h000;
            tick_q <= 1'b0;
            trq_raw_q <= 16'sh0000;
        end else begin
            sync1_q <= {i_servo_on_input, i_torque_select_bit_a, i_torque_select_bit_b};
            sync2_q <= sync1_q;
            sel_q <= sel_d;
            tcnt_q <= tcnt_d;
            tick_q <= tick_d;
            trq_raw_q <= trq_raw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed / position ramp generator
    always_comb begin
        pos_mode = legal && (mode == torque_cmd_pkg::PULSE_POSITION_MODE ||
            mode == torque_cmd_pkg::PROGRAM_POSITION_MODE);
        spd_mode = legal && (mode == torque_cmd_pkg::SPEED_MODE ||
            mode == torque_cmd_pkg::ZERO_SPEED_REGISTER_MODE);
        acc_t = spd_mode ? cfg_q[I_SACC] : ptime_q[cfg_q[I_CTRL][7:4]]; // [R12] [R10]
        dec_t = spd_mode ? cfg_q[I_SDEC] : ptime_q[cfg_q[I_CTRL][7:4]]; // [R12]
        // Pulse input already has continuous speed: ramp times forced to zero
        if (mode == torque_cmd_pkg::PULSE_POSITION_MODE) begin
            acc_t = 16'h0000;
            dec_t = 16'h0000;
        end
        sm_t = pos_mode ? cfg_q[I_PSM] : cfg_q[I_SSM];
        smooth_on = (pos_mode || spd_mode) && (sm_t > 16'h0001); // [R14]
        if (sm_t == 16'h0000) begin
            comp_d = 1'b0; // [R15]
        end else if (sm_t == 16'h0001) begin
            comp_d = 1'b1;
        end else begin
            comp_d = cfg_q[I_CTRL][torque_cmd_pkg::CTRL_COMP_EN_BIT];
        end
        comp_d = comp_d && (pos_mode || spd_mode);
        tgt = (pos_mode || spd_mode) ? i_speed_target : 16'sh0000;
        diff = 17'(tgt) - 17'(cur_q); // [R16]
        mag = diff[16] ? 16'(-diff) : diff[15:0];
        // Magnitude grows or sign flips: accel slope, else decel slope
        ramp_t = ((tgt[15] != cur_q[15]) || ((tgt[15] ? -tgt : tgt) >
            (cur_q[15] ? -cur_q : cur_q))) ? acc_t : dec_t; // [R12] [R13]
        cur_d = cur_q;
        pcnt_d = pcnt_q;
        tgt_last_d = tgt_last_q;
        exec_d = exec_q;
        if (tick_q) begin
            tgt_last_d = tgt;
            if (tgt != tgt_last_q) begin
                exec_d = 32'(mag) * 32'({1'b0, ramp_t} + 17'h00001); // [R16]
            end else if (exec_q != 32'h0000_0000) begin
                exec_d = exec_q - 32'h0000_0001;
            end
            if (diff == 17'sh00000) begin
                pcnt_d = 16'h0000;
            end else if (pcnt_q >= ramp_t) begin
                cur_d = diff[16] ? cur_q - 16'sh0001 : cur_q + 16'sh0001; // [R13]
                pcnt_d = 16'h0000;
            end else begin
                pcnt_d = pcnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cur_q <= 16'sh0000;
            pcnt_q <= 16'h0000;
            tgt_last_q <= 16'sh0000;
            exec_q <= 32'h0000_0000;
        end else begin
            cur_q <= cur_d;
            pcnt_q <= pcnt_d;
            tgt_last_q <= tgt_last_d;
            exec_q <= exec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filters; moving average smooths both ends of a ramp, lowpass only the end
    assign f_trq.tick = o_sample_tick; // Runs after raw latch: new source shows same sample
    assign f_trq.x = trq_raw_q;
    assign f_trq.time_set = cfg_q[I_TLPF]; // [R11]
    assign f_smooth.tick = tick_q;
    assign f_smooth.x = cur_q;
    assign f_smooth.time_set = smooth_on ? sm_t : 16'h0000; // [R14]
    assign f_cmd.tick = tick_q;
    assign f_cmd.x = ma_on ? mavg : f_smooth.y;
    assign f_cmd.time_set = pos_mode ? cfg_q[I_PLPF] : cfg_q[I_VLPF]; // [R17]

    cmd_filter u_trq (.i_clock(i_clock), .i_resetn(i_resetn), .f(f_trq.flt));
    cmd_filter u_smooth (.i_clock(i_clock), .i_resetn(i_resetn), .f(f_smooth.flt));
    cmd_filter u_cmd (.i_clock(i_clock), .i_resetn(i_resetn), .f(f_cmd.flt));

    always_comb begin
        ma_on = spd_mode && (cfg_q[I_VMOV] != 16'h0000); // [R11] [R17]
        mk = (cfg_q[I_VMOV] > 16'h0003) ? 2'b11 : cfg_q[I_VMOV][1:0];
        msum = 19'sh00000;
        for (int i = 0; i < 8; i++) begin
            if (i < (1 << mk)) begin
                msum = msum + 19'(hist_q[i]);
            end
        end
        mavg = 16'(msum >>> mk);
        hist_d = hist_q;
        if (tick_q) begin
            hist_d[0] = f_smooth.y;
            for (int i = 1; i < 8; i++) begin
                hist_d[i] = hist_q[i - 1];
            end
        end
        trq_out_d = f_trq.y;
        spd_out_d = f_cmd.y;
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            for (int i = 0; i < 8; i++) begin
                hist_q[i] <= 16'sh0000;
            end
            o_torque_cmd <= 16'sh0000;
            o_torque_limit <= 16'h0000;
            o_speed_cmd <= 16'sh0000;
            o_follow_comp_on <= 1'b0;
            o_sample_tick <= 1'b0;
        end else begin
            hist_q <= hist_d;
            o_torque_cmd <= trq_out_d;
            o_torque_limit <= tlim_d;
            o_speed_cmd <= spd_out_d;
            o_follow_comp_on <= comp_d; // [R15]
            o_sample_tick <= tick_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_analog_src;
        @(posedge i_clock) disable iff (!i_resetn)
        (tick_q && sync2_q[2] && legal && mode == torque_cmd_pkg::TORQUE_MODE
            && sel_q == 2'b00) |=> (trq_raw_q == $past(scaled));
    endproperty
    a_analog_src: assert property (p_analog_src) else $error("analog not used"); // [R1]
    property p_zero_src;
        @(posedge i_clock) disable iff (!i_resetn)
        (tick_q && mode == torque_cmd_pkg::ZERO_TORQUE_REGISTER_MODE && sel_q == 2'b00)
            |=> (trq_raw_q == 16'sh0000);
    endproperty
    a_zero_src: assert property (p_zero_src) else $error("zero source not zero"); // [R4]
    property p_preset3;
        @(posedge i_clock) disable iff (!i_resetn)
        (tick_q && sync2_q[2] && mode == torque_cmd_pkg::TORQUE_MODE && sel_q == 2'b11)
            |=> (trq_raw_q == $signed($past(cfg_q[I_P1 + 4'h2])));
    endproperty
    a_preset3: assert property (p_preset3) else $error("preset 3 not chosen"); // [R3]
    property p_sel_hold;
        @(posedge i_clock) disable iff (!i_resetn)
        !sync2_q[2] |=> $stable(sel_q);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved with servo off"); // [R5]
    property p_io_src;
        @(posedge i_clock) disable iff (!i_resetn)
        (tick_q && sync2_q[2] && mode == torque_cmd_pkg::IO_MODE)
            |=> (trq_raw_q == $signed($past(cfg_q[I_IO])));
    endproperty
    a_io_src: assert property (p_io_src) else $error("io path not used"); // [R6]
    property p_scale_rst;
        @(posedge i_clock) !i_resetn |=> (cfg_q[I_SCALE] == 16'h0064);
    endproperty
    a_scale_rst: assert property (p_scale_rst) else $error("scale reset wrong"); // [R8]
    property p_tick_rate;
        @(posedge i_clock) disable iff (!i_resetn)
        $rose(tick_q) |=> !tick_q [*8];
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("sample tick too fast"); // [R19]
    property p_comp;
        @(posedge i_clock) disable iff (!i_resetn)
        (spd_mode && cfg_q[I_SSM] == 16'h0001) [*2] |-> o_follow_comp_on;
    endproperty
    a_comp: assert property (p_comp) else $error("compensation not on"); // [R15]
    c_analog: cover property (@(posedge i_clock) tick_q && mode == torque_cmd_pkg::TORQUE_MODE
        && sel_q == 2'b00 && i_analog_torque != 12'sh000);
    c_preset: cover property (@(posedge i_clock) tick_q && sel_q == 2'b01 && sync2_q[2]);
    c_ramp: cover property (@(posedge i_clock) spd_mode && tick_q && cur_q != tgt);
endmodule
`default_nettype wire

// >>> torque_pin_host.sv
`default_nettype none
module torque_pin_host (
    input wire logic i_clock,
    input wire logic [1:0] i_sel,
    input wire logic i_servo,
    output logic o_sel_a,
    output logic o_sel_b,
    output logic o_servo
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts move just after an edge; the design must sync them itself
    always @(posedge i_clock) begin
        o_sel_a <= i_sel[1];
        o_sel_b <= i_sel[0];
        o_servo <= i_servo;
    end
endmodule
`default_nettype wire

// >>> tb_torque_command_select.sv
`default_nettype none
module tb_torque_command_select;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [2:0] mode; logic [1:0] sel; logic servo_on_input; logic [11:0] ana;
        logic [15:0] exp;} row_s;
    row_s rows [8] = '{'{3'h4, 2'h0, 1'b1, 12'h01F4, 16'h0032},
        '{3'h4, 2'h1, 1'b1, 12'h01F4, 16'h0011}, '{3'h4, 2'h2, 1'b1, 12'h01F4, 16'h0022},
        '{3'h4, 2'h3, 1'b1, 12'h01F4, 16'h0033}, '{3'h5, 2'h0, 1'b1, 12'h01F4, 16'h0000},
        '{3'h6, 2'h0, 1'b1, 12'h01F4, 16'h0044}, '{3'h4, 2'h2, 1'b0, 12'h01F4, 16'h0000},
        '{3'h7, 2'h0, 1'b1, 12'h01F4, 16'h0000}};
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err, sa, sb, sv, servo_on_input = 1'b0, comp, tick;
    logic [1:0] sel = 2'h0;
    logic signed [11:0] ana = 12'h000;
    logic signed [15:0] trq, spd, tgt = 16'sh0000;
    logic [15:0] lim;
    int bad_count = 0, n_tests = 0;
    initial forever #25 clock = ~clock;
    torque_pin_host i_host (.i_clock(clock), .i_sel(sel), .i_servo(servo_on_input), .o_sel_a(sa),
        .o_sel_b(sb), .o_servo(sv));
    torque_command_select i_dut (.i_clock(clock), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_torque_select_bit_a(sa), .i_torque_select_bit_b(sb), .i_servo_on_input(sv),
        .i_analog_torque(ana), .i_speed_target(tgt), .o_torque_cmd(trq),
        .o_torque_limit(lim), .o_speed_cmd(spd), .o_follow_comp_on(comp),
        .o_sample_tick(tick));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        if (n >= 20) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Two ticks cover pin sync plus the latch tick
    task automatic settle();
        repeat (2) begin
            do @(posedge clock); while (tick !== 1'b1);
        end
        repeat (5) @(posedge clock);
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clock);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, torque_cmd_pkg::OFS_ANA_SCALE, 32'h0000_0000);
        check("scale reset", 32'h0000_0064, q);
        apb(1'b1, torque_cmd_pkg::OFS_PRESET_1, 32'h0000_0011);
        apb(1'b1, torque_cmd_pkg::OFS_PRESET_2, 32'h0000_0022);
        apb(1'b1, torque_cmd_pkg::OFS_PRESET_3, 32'h0000_0033);
        apb(1'b1, torque_cmd_pkg::OFS_IO_TORQUE, 32'h0000_0044);
        apb(1'b1, torque_cmd_pkg::OFS_TRQ_LPF, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, torque_cmd_pkg::OFS_CTRL, {29'h0000_0000, rows[i].mode});
            sel <= rows[i].sel;
            servo_on_input <= rows[i].servo_on_input;
            ana <= rows[i].ana;
            settle();
            check("torque", {16'h0000, rows[i].exp}, {16'h0000, trq});
        end
        apb(1'b1, torque_cmd_pkg::OFS_CTRL, 32'h0000_0004);
        sel <= 2'h1;
        servo_on_input <= 1'b1;
        apb(1'b1, torque_cmd_pkg::OFS_PRESET_1, 32'h0000_0055);
        settle();
        check("new preset", 32'h0000_0055, {16'h0000, trq});
        sel <= 2'h0;
        ana <= 12'h3E8;
        apb(1'b1, torque_cmd_pkg::OFS_ANA_SCALE, 32'h0000_012C);
        settle();
        check("torque 300", 32'h0000_012C, {16'h0000, trq});
        check("limit", 32'h0000_0064, {16'h0000, lim});
        ana <= 12'h7FF;
        apb(1'b1, torque_cmd_pkg::OFS_ANA_SCALE, 32'h0000_FFFF);
        settle();
        check("clamp", 32'h0000_7FFF, {16'h0000, trq});
        apb(1'b0, 12'h03C, 32'h0000_0000);
        check("unmapped", 32'h0000_0001, {31'h0000_0000, err});
        check("unmapped data", 32'h0000_0000, q);
        apb(1'b1, torque_cmd_pkg::OFS_STATUS, 32'h0000_0001);
        check("ro write", 32'h0000_0001, {31'h0000_0000, err});
        // Speed mode: smoothing 0,1,2 then 2 with the enable bit
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, torque_cmd_pkg::OFS_CTRL, {28'h000_0000, k == 3, 3'h2});
            apb(1'b1, torque_cmd_pkg::OFS_SC_SMOOTH, (k == 3) ? 32'h0000_0002 : 32'(k));
            settle();
            check("follow comp", {31'h0000_0000, k[0]}, {31'h0000_0000, comp});
            apb(1'b0, torque_cmd_pkg::OFS_STATUS, 32'h0000_0000);
            check("smoothing", {31'h0000_0000, k > 1}, {31'h0000_0000, q[18]});
        end
        // Speed ramp, times all zero: one unit per sample, two filter stages behind
        apb(1'b1, torque_cmd_pkg::OFS_SC_SMOOTH, 32'h0000_0000);
        apb(1'b1, torque_cmd_pkg::OFS_VEL_LPF, 32'h0000_0000);
        tgt <= 16'sh0003;
        // Skip a tick that was launched before the target moved
        @(posedge clock);
        settle();
        apb(1'b0, torque_cmd_pkg::OFS_EXEC_TIME, 32'h0000_0000);
        check("exec time", 32'h0000_0002, q);
        repeat (2) settle();
        check("speed", 32'h0000_0003, {16'h0000, spd});
        apb(1'b0, torque_cmd_pkg::OFS_EXEC_TIME, 32'h0000_0000);
        check("exec done", 32'h0000_0000, q);
        test_done();
    end
endmodule
`default_nettype wire
